// ===== lmm_consts.svh
`ifndef LMM_CONSTS_SVH
`define LMM_CONSTS_SVH

// register bus map (byte addresses)
`define LMM_ADR_CTRL       8'h00
`define LMM_ADR_STAT       8'h04
`define LMM_ADR_ACC        8'h08
`define LMM_ADR_BANK       8'h0c
`define LMM_ADR_PTR0       8'h10
`define LMM_ADR_PTR1       8'h14
`define LMM_ADR_PTR2       8'h18
`define LMM_ADR_PROD       8'h1c

// control and status fields
`define LMM_CTRL_RUN_BIT   0
`define LMM_CTRL_EXT_BIT   1
`define LMM_CTRL_RST       2'h1
`define LMM_STAT_ZERO_BIT  0
`define LMM_STAT_SIGN_BIT  1
`define LMM_STAT_UNK_BIT   2

// opcode patterns
`define LMM_OPC_OR_IMM     8'h09
`define LMM_OPC_IMM_LOAD   8'h0e
`define LMM_OPC_BANK_LOAD  8'h01
`define LMM_OPC_IMM_PROD   8'h0d
`define LMM_OPC_OR_REG     6'h04
`define LMM_OPC_COPY_REG   6'h14
`define LMM_OPC_ACC_STORE  7'h37
`define LMM_OPC_REG_COPY   4'hc
`define LMM_OPC_LOAD_PTR   10'h3b8
`define LMM_OPC_OPERAND    4'hf

// data space layout
`define LMM_ACC_ADDR       12'hfe8
`define LMM_ACCESS_SPLIT   8'h60
`define LMM_ILO_LIMIT      8'h5f
`define LMM_ACCESS_LO_BANK 4'h0
`define LMM_ACCESS_HI_BANK 4'hf
`define LMM_PTR_INDEXED    2

// reset values
`define LMM_BANK_RST       8'h00
`define LMM_PTR_RST        12'h000
`define LMM_ACC_RST        8'h00
`define LMM_PROD_RST       16'h0000

`endif

// ===== lmm_data_ram.sv
`timescale 1ns/1ps

module lmm_data_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // read port, data one cycle after the strobe
  input  wire logic          rd_en_i,
  input  wire logic [AW-1:0] rd_adr_i,
  output logic      [DW-1:0] rd_dat_o,
  // write port
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_adr_i,
  input  wire logic [DW-1:0] wr_dat_i
);

  generate
    if (AW < 1 || AW > 16 || DW < 1) begin : g_bad
      $error("lmm_data_ram: unsupported geometry");
    end
  endgenerate

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_q;

  // contents are not reset; software must initialise what it reads
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_adr_i] <= wr_dat_i;
    end
  end

  // registered read keeps the output a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= '0;
    end else if (rd_en_i) begin
      rd_q <= mem_q[rd_adr_i];
    end
  end

  assign rd_dat_o = rd_q;

endmodule

// ===== lmm_exec.sv
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "lmm_consts.svh"


module lmm_exec #(
  parameter int DATA_AW = 12
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // program memory words
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  output logic             instr_ready_o,
  // retire strobe
  output logic             instr_done_o
);

  generate
    if (DATA_AW != 12) begin : g_bad
      $error("lmm_exec: data space must be 12 address bits");
    end
  endgenerate

  // bank resolution shared by the read and write paths
  function automatic logic [11:0] resolve_addr(input logic [7:0]  f,
                                               input logic        acc_n,
                                               input logic [7:0]  bank,
                                               input logic        ext,
                                               input logic [11:0] base);
    logic [11:0] a;
    a = {bank[3:0], f};
    if (!acc_n) begin
      if (ext && f <= `LMM_ILO_LIMIT) begin
        a = base + {4'h0, f};
      end else if (f < `LMM_ACCESS_SPLIT) begin
        a = {`LMM_ACCESS_LO_BANK, f};
      end else begin
        a = {`LMM_ACCESS_HI_BANK, f};
      end
    end
    return a;
  endfunction

  // state
  lmm_pkg::lmm_phase_e phase_q, phase_d;
  lmm_pkg::lmm_instr_s ins_q;
  logic                second_q;
  logic [15:0]         word2_q;
  logic [11:0]         raddr_q;
  logic [7:0]          opnd_q;
  logic [7:0]          acc_q;
  logic [7:0]          bank_q;
  logic [11:0]         ptr_q [3];
  logic [15:0]         prod_q;
  logic                zero_q;
  logic                sign_q;
  logic                unk_q;
  logic [1:0]          ctrl_q;
  logic                done_q;
  logic                ack_q;
  logic [31:0]         dat_q;

  // decode of the incoming word
  wire [7:0]  hi8       = instr_i[15:8];
  wire        d_or_imm  = hi8 == `LMM_OPC_OR_IMM;
  wire        d_imm_ld  = hi8 == `LMM_OPC_IMM_LOAD;
  wire        d_bank_ld = hi8 == `LMM_OPC_BANK_LOAD;
  wire        d_prod    = hi8 == `LMM_OPC_IMM_PROD;
  wire        d_or_reg  = instr_i[15:10] == `LMM_OPC_OR_REG;
  wire        d_copy    = instr_i[15:10] == `LMM_OPC_COPY_REG;
  wire        d_store   = instr_i[15:9] == `LMM_OPC_ACC_STORE;
  wire        d_rcopy   = instr_i[15:12] == `LMM_OPC_REG_COPY;
  wire        d_ldptr   = instr_i[15:6] == `LMM_OPC_LOAD_PTR && instr_i[5:4] != 2'h3;
  lmm_pkg::lmm_op_e dec_op;
  assign dec_op = d_or_imm  ? lmm_pkg::OP_OR_IMM :
                  d_or_reg  ? lmm_pkg::OP_OR_REG :
                  d_copy    ? lmm_pkg::OP_COPY_REG :
                  d_store   ? lmm_pkg::OP_ACC_STORE :
                  d_imm_ld  ? lmm_pkg::OP_IMM_LOAD :
                  d_bank_ld ? lmm_pkg::OP_BANK_LOAD :
                  d_prod    ? lmm_pkg::OP_IMM_PRODUCT :
                  d_ldptr   ? lmm_pkg::OP_LOAD_PTR :
                  d_rcopy   ? lmm_pkg::OP_REG_COPY : lmm_pkg::OP_NONE;

  // handshake with program memory; a missing word stalls in decode
  wire run      = ctrl_q[`LMM_CTRL_RUN_BIT];
  wire ext_en   = ctrl_q[`LMM_CTRL_EXT_BIT];
  assign instr_ready_o = run && phase_q == lmm_pkg::PH_DECODE;
  wire take     = instr_valid_i && instr_ready_o;

  // fields of the latched first word
  lmm_pkg::lmm_op_e op;
  assign op = ins_q.op;
  wire [7:0]  lit      = ins_q.field[7:0];
  wire        dest_reg = ins_q.field[9];
  wire        acc_n    = ins_q.field[8];
  wire [1:0]  psel     = ins_q.field[5:4];
  wire        two_word = op == lmm_pkg::OP_LOAD_PTR || op == lmm_pkg::OP_REG_COPY;
  wire        is_or_r  = op == lmm_pkg::OP_OR_REG;
  wire        is_copy  = op == lmm_pkg::OP_COPY_REG;
  wire        is_store = op == lmm_pkg::OP_ACC_STORE;
  wire        is_rcopy = op == lmm_pkg::OP_REG_COPY;

  // operand read only in the first cycle
  wire        reads    = is_or_r || is_copy || is_store || is_rcopy;
  wire        rd_en    = phase_q == lmm_pkg::PH_READ && !second_q && reads;
  wire [11:0] rd_adr   = is_rcopy ? ins_q.field
                                  : resolve_addr(lit, acc_n, bank_q, ext_en, ptr_q[`LMM_PTR_INDEXED]);
  wire [7:0]  mem_rd;

  // result and destination in the write phase
  wire        wr_ph    = phase_q == lmm_pkg::PH_WRITE;
  wire [7:0]  or_src   = op == lmm_pkg::OP_OR_IMM ? lit : opnd_q;
  wire [7:0]  or_res   = acc_q | or_src;
  wire [7:0]  result   = (is_copy || is_rcopy) ? opnd_q : is_store ? acc_q : or_res;
  wire        to_file  = !second_q && (((is_or_r || is_copy) && dest_reg) || is_store);
  wire        rc_wr    = second_q && is_rcopy;
  wire [11:0] wr_adr   = rc_wr ? word2_q[11:0] : raddr_q;
  wire        file_wr  = wr_ph && (to_file || rc_wr);
  wire        hits_acc = wr_adr == `LMM_ACC_ADDR;
  lmm_pkg::lmm_mem_wr_s mem_wr;
  assign mem_wr.en  = file_wr && !hits_acc;
  assign mem_wr.adr = wr_adr;
  assign mem_wr.dat = result;
  wire        acc_from_op = !second_q && (op == lmm_pkg::OP_OR_IMM ||
                            ((is_or_r || is_copy) && !dest_reg));
  wire        acc_wr   = wr_ph && (acc_from_op || op == lmm_pkg::OP_IMM_LOAD ||
                                   (file_wr && hits_acc));
  wire [7:0]  acc_d    = op == lmm_pkg::OP_IMM_LOAD && !second_q ? lit : result;
  wire        flag_wr  = wr_ph && !second_q && (op == lmm_pkg::OP_OR_IMM || is_or_r || is_copy);
  wire        retire   = wr_ph && (second_q || !two_word);

  lmm_data_ram #(
    .AW (DATA_AW),
    .DW (8)
  ) u_ram (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .rd_en_i  (rd_en),
    .rd_adr_i (rd_adr),
    .rd_dat_o (mem_rd),
    .wr_en_i  (mem_wr.en),
    .wr_adr_i (mem_wr.adr),
    .wr_dat_i (mem_wr.dat)
  );

  // phase sequencer
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      lmm_pkg::PH_DECODE: phase_d = take ? lmm_pkg::PH_READ : lmm_pkg::PH_DECODE;
      lmm_pkg::PH_READ:   phase_d = lmm_pkg::PH_PROC;
      lmm_pkg::PH_PROC:   phase_d = lmm_pkg::PH_WRITE;
      lmm_pkg::PH_WRITE:  phase_d = lmm_pkg::PH_DECODE;
      default:            phase_d = lmm_pkg::PH_DECODE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= lmm_pkg::PH_DECODE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // instruction capture; the second word is kept as operand only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ins_q   <= '{op: lmm_pkg::OP_NONE, field: 12'h000};
      word2_q <= 16'h0000;
    end else if (take && !second_q) begin
      ins_q <= '{op: dec_op, field: instr_i[11:0]};
    end else if (take) begin
      word2_q <= instr_i;
    end
  end

  // second cycle of a two-word instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_q <= 1'b0;
    end else if (wr_ph) begin
      second_q <= !second_q && two_word;
    end
  end

  // operand capture; the accumulator answers for its own address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raddr_q <= 12'h000;
      opnd_q  <= 8'h00;
    end else if (rd_en) begin
      raddr_q <= rd_adr;
    end else if (phase_q == lmm_pkg::PH_PROC && !second_q) begin
      opnd_q <= raddr_q == `LMM_ACC_ADDR ? acc_q : mem_rd;
    end
  end

  // accumulator and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= `LMM_ACC_RST;
    end else if (acc_wr) begin
      acc_q <= acc_d;
    end
  end

  // sign and zero only; stores, two-word copies and products leave them alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_q <= 1'b0;
      sign_q <= 1'b0;
    end else if (flag_wr) begin
      zero_q <= result == 8'h00;
      sign_q <= result[7];
    end
  end

  // bank select, upper nibble always zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_q <= `LMM_BANK_RST;
    end else if (wr_ph && !second_q && op == lmm_pkg::OP_BANK_LOAD) begin
      bank_q <= {4'h0, lit[3:0]};
    end
  end

  // product pair; accumulator untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prod_q <= `LMM_PROD_RST;
    end else if (wr_ph && !second_q && op == lmm_pkg::OP_IMM_PRODUCT) begin
      prod_q <= {8'h00, acc_q} * {8'h00, lit};
    end
  end

  // indirect pointers: high nibble in cycle one, low byte in cycle two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= '{default: `LMM_PTR_RST};
    end else if (wr_ph && op == lmm_pkg::OP_LOAD_PTR) begin
      if (!second_q) begin
        ptr_q[psel][11:8] <= ins_q.field[3:0];
      end else begin
        ptr_q[psel][7:0] <= word2_q[7:0];
      end
    end
  end

  // retire pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= retire;
    end
  end

  assign instr_done_o = done_q;

  // bus decode; writes land on the edge that the master sees ack
  wire        bus_hit  = wb_cyc_i && wb_stb_i;
  wire        bus_wr   = bus_hit && ack_q && wb_we_i && wb_sel_i[0];
  wire        wr_ctrl  = bus_wr && wb_adr_i == `LMM_ADR_CTRL;
  wire        clr_unk  = bus_wr && wb_adr_i == `LMM_ADR_STAT && wb_dat_i[`LMM_STAT_UNK_BIT];
  wire        set_unk  = take && !second_q && dec_op == lmm_pkg::OP_NONE;
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (wb_adr_i)
      `LMM_ADR_CTRL: rd_word = {30'h0, ctrl_q};
      `LMM_ADR_STAT: rd_word = {29'h0, unk_q, sign_q, zero_q};
      `LMM_ADR_ACC:  rd_word = {24'h0, acc_q};
      `LMM_ADR_BANK: rd_word = {24'h0, bank_q};
      `LMM_ADR_PTR0: rd_word = {20'h0, ptr_q[0]};
      `LMM_ADR_PTR1: rd_word = {20'h0, ptr_q[1]};
      `LMM_ADR_PTR2: rd_word = {20'h0, ptr_q[2]};
      `LMM_ADR_PROD: rd_word = {16'h0, prod_q};
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  // one wait state; unmapped addresses read zero and still ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_hit && !ack_q;
      dat_q <= bus_hit && !ack_q ? rd_word : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `LMM_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wb_dat_i[1:0];
    end
  end

  // sticky unknown-opcode flag, a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unk_q <= 1'b0;
    end else if (set_unk) begin
      unk_q <= 1'b1;
    end else if (clr_unk) begin
      unk_q <= 1'b0;
    end
  end

endmodule

// ===== lmm_exec_sva.sv
`timescale 1ns/1ps
`include "lmm_consts.svh"

module lmm_exec_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // program memory
  input wire logic        instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic        instr_ready_o,
  input wire logic        instr_done_o
);
  // word taken, and whether it opens a two-word op
  wire  take = instr_valid_i & instr_ready_o;
  // pointer select 3 is no load, so it stays a one-word unknown op
  wire  two  = instr_i[15:12] == `LMM_OPC_REG_COPY ||
               (instr_i[15:6] == `LMM_OPC_LOAD_PTR && instr_i[5:4] != 2'h3);
  logic sec_q;

  // operand words look like anything, so track them here
  always_ff @(posedge clk_i) begin
    if (rst_i) sec_q <= 1'b0;
    else if (take) sec_q <= two & ~sec_q;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_WAIT: assert property ($rose(wb_cyc_i & wb_stb_i) |=> wb_ack_o)
    else $error("bus ack not one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  AST_RDY_GAP: assert property (take |=> !instr_ready_o [*3])
    else $error("ready back before four phases");
  AST_ONE_WORD: assert property (take && !two && !sec_q |=> !instr_done_o [*3] ##1 instr_done_o)
    else $error("single word op not retired after four phases");
  AST_FIRST_WORD: assert property (take && two && !sec_q |=> !instr_done_o [*4])
    else $error("two word op retired after first word");
  AST_SECOND_WORD: assert property (take && sec_q |=> !instr_done_o [*3] ##1 instr_done_o)
    else $error("two word op not retired after second word");
  AST_DONE_PULSE: assert property (instr_done_o |=> !instr_done_o)
    else $error("done longer than one cycle");
  AST_RST_OUT: assert property ($fell(rst_i) |-> instr_ready_o && !wb_ack_o && !instr_done_o)
    else $error("outputs wrong after reset");
endmodule

bind lmm_exec lmm_exec_sva lmm_exec_sva_i (
  .clk_i        (clk_i),
  .rst_i        (rst_i),
  .wb_cyc_i     (wb_cyc_i),
  .wb_stb_i     (wb_stb_i),
  .wb_dat_o     (wb_dat_o),
  .wb_ack_o     (wb_ack_o),
  .instr_valid_i(instr_valid_i),
  .instr_i      (instr_i),
  .instr_ready_o(instr_ready_o),
  .instr_done_o (instr_done_o)
);

// ===== lmm_exec_tb.sv
`timescale 1ns/1ps
`include "lmm_consts.svh"

module lmm_exec_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, valid, ready, wb_ack_o, instr_done_o;
  logic [7:0]  adr = 8'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, q, wb_dat_o;
  logic [15:0] word;
  int          failures = 0, checked = 0, seed = 14460, pend = 0;
  int          m_acc, m_bank, m_prod, m_z, m_n, m_unk, m_ext, m_ptr[3], mem[4096];
  bit          known[4096];
  int          ftab[4] = '{0, 95, 96, 232};

  always #10 clk_i = ~clk_i;

  lmm_exec lmm_exec_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .instr_valid_i(valid), .instr_i(word), .instr_ready_o(ready),
    .instr_done_o(instr_done_o));
  lmm_prog_mem lmm_prog_mem_i (.clk_i(clk_i), .rst_i(rst_i), .ready_i(ready),
    .valid_o(valid), .word_o(word));

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // classic single cycle; the slave sets the pace, a stuck one ends the wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) chk(32'h0, 32'hffffffff);
  endtask

  task automatic rd(input logic [7:0] a, input int e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(q, e);
  endtask

  // model of bank resolution
  function automatic int ea(int a, int f);
    if (a) return m_bank * 256 + f;
    if (m_ext && f <= 95) return (m_ptr[2] + f) % 4096;
    return f < 96 ? f : 12'hf00 | f;
  endfunction

  function automatic int setf(int v);
    m_z = v == 0;
    m_n = v / 128;
    return v;
  endfunction

  // accumulator lives in the data space too
  function automatic int rdm(int a);
    return a == 12'hfe8 ? m_acc : mem[a];
  endfunction

  task automatic wrm(int a, int v);
    known[a] = 1'b1;
    if (a == 12'hfe8) m_acc = v;
    else mem[a] = v;
  endtask

  task automatic wait_done();
    int t;
    t = 0;
    while (pend > 0 && t < 300) begin
      @(posedge clk_i);
      t++;
      if (instr_done_o === 1'b1) pend--;
    end
    if (pend > 0) chk(32'h0, pend);
    pend = 0;
  endtask

  task automatic check_all();
    rd(`LMM_ADR_ACC, m_acc);
    rd(`LMM_ADR_STAT, m_unk * 4 + m_n * 2 + m_z);
    rd(`LMM_ADR_BANK, m_bank);
    rd(`LMM_ADR_PROD, m_prod);
    rd(`LMM_ADR_PTR0, m_ptr[0]);
    rd(`LMM_ADR_PTR1, m_ptr[1]);
    rd(`LMM_ADR_PTR2, m_ptr[2]);
  endtask

  // one random instruction; reads of untouched memory become stores
  task automatic step(input bit hold);
    int op, k, d, a, f, e, x, p, af;
    logic [15:0] w1, w2;
    op = {$random(seed)} % 10;
    k = {$random(seed)} % 256;
    d = k % 2;
    a = {$random(seed)} % 2;
    f = ftab[{$random(seed)} % 4];
    af = d * 512 + a * 256 + f;
    e = ea(a, f);
    x = ea({$random(seed)} % 2, ftab[{$random(seed)} % 4]);
    if ((op == 1 || op == 2 || op == 8) && !known[e]) op = 3;
    if (x >= 12'hff9) x = 12'hfe8;
    w2 = 16'hf000 | 16'(x);
    case (op)
      0: begin
        w1 = 16'h0900 | 16'(k);
        m_acc = setf(m_acc | k);
      end
      1, 2: begin
        w1 = (op == 1 ? 16'h1000 : 16'h5000) | 16'(af);
        p = setf(op == 1 ? m_acc | rdm(e) : rdm(e));
        if (d) wrm(e, p);
        else m_acc = p;
      end
      3: begin
        w1 = 16'h6e00 | 16'(af);
        wrm(e, m_acc);
      end
      4: begin
        w1 = 16'h0e00 | 16'(k);
        m_acc = k;
      end
      5: begin
        w1 = 16'h0100 | 16'(k);
        m_bank = k % 16;
      end
      6: begin
        w1 = 16'h0d00 | 16'(k);
        m_prod = m_acc * k;
      end
      7: begin
        p = k % 3;
        x = (k / 4) % 2 ? 12'hfff : k % 16;
        w1 = 16'hee00 | 16'(p * 16 + x / 256);
        w2 = 16'hf000 | 16'(x % 256);
        m_ptr[p] = x;
      end
      8: begin
        w1 = 16'hc000 | 16'(e);
        wrm(x, rdm(e));
      end
      default: begin
        // pointer select 3 looks like a two-word op but must run as one unknown word
        w1 = d ? 16'hee30 | 16'(k % 16) : 16'h0300 | 16'(k);
        m_unk = 1;
      end
    endcase
    lmm_prog_mem_i.words.push_back(w1);
    if (op == 7 || op == 8) lmm_prog_mem_i.words.push_back(w2);
    pend++;
    if (!hold) begin
      wait_done();
      check_all();
    end
  endtask

  // watchdog, well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clk_i);
    chk(32'h0, 32'h1);
    print_verdict();
  end

  initial begin
    known[12'hfe8] = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`LMM_ADR_CTRL, 1);
    check_all();
    rd(8'h20, 0);
    wb(1'b1, `LMM_ADR_CTRL, 32'h2, 4'he);
    rd(`LMM_ADR_CTRL, 1);
    $display("test reset done");
    // bursts of four back to back, then a check
    for (int i = 0; i < 240; i++) begin
      step(i % 4 != 3);
      if (i % 16 == 15) begin
        m_ext = {$random(seed)} % 2;
        wb(1'b1, `LMM_ADR_CTRL, m_ext * 2 + 1, 4'h1);
        wb(1'b1, `LMM_ADR_STAT, 32'h4, 4'h1);
        m_unk = 0;
      end
    end
    $display("test random done");
    // stopped core must leave a waiting word alone
    wb(1'b1, `LMM_ADR_CTRL, 32'h0, 4'h1);
    lmm_prog_mem_i.words.push_back(16'h0e5a);
    repeat (8) @(posedge clk_i);
    chk({31'h0, ready}, 32'h0);
    rd(`LMM_ADR_ACC, m_acc);
    wb(1'b1, `LMM_ADR_CTRL, 32'h1, 4'h1);
    m_ext = 0;
    m_acc = 8'h5a;
    pend = 1;
    wait_done();
    check_all();
    $display("test stop done");
    print_verdict();
  end
endmodule

// ===== lmm_pkg.sv
package lmm_pkg;

  // one instruction cycle, one state per phase
  typedef enum logic [3:0] {
    PH_DECODE = 4'b0001,
    PH_READ   = 4'b0010,
    PH_PROC   = 4'b0100,
    PH_WRITE  = 4'b1000
  } lmm_phase_e;

  // executed operations
  typedef enum logic [9:0] {
    OP_NONE        = 10'b0000000001,
    OP_OR_IMM      = 10'b0000000010,
    OP_OR_REG      = 10'b0000000100,
    OP_COPY_REG    = 10'b0000001000,
    OP_ACC_STORE   = 10'b0000010000,
    OP_IMM_LOAD    = 10'b0000100000,
    OP_BANK_LOAD   = 10'b0001000000,
    OP_IMM_PRODUCT = 10'b0010000000,
    OP_LOAD_PTR    = 10'b0100000000,
    OP_REG_COPY    = 10'b1000000000
  } lmm_op_e;

  // decoded first word: operation plus low twelve bits
  typedef struct packed {
    lmm_op_e     op;
    logic [11:0] field;
  } lmm_instr_s;

  // one data memory write
  typedef struct packed {
    logic        en;
    logic [11:0] adr;
    logic [7:0]  dat;
  } lmm_mem_wr_s;

endpackage

// ===== lmm_prog_mem.sv
`timescale 1ns/1ps

module lmm_prog_mem (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // word handshake
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic [15:0]      word_o
);
  logic [15:0] words[$];
  int          cnt_q = 0;

  initial begin
    valid_o = 1'b0;
    word_o  = 16'h0;
  end

  // hold each word until taken; idle lines toggle so no stale word looks valid
  always @(posedge clk_i) begin
    cnt_q <= cnt_q + 1;
    if (rst_i) begin
      valid_o <= 1'b0;
    end else if (valid_o && ready_i) begin
      void'(words.pop_front());
      valid_o <= 1'b0;
      word_o  <= ~word_o;
    end else if (!valid_o && words.size() > 0 && cnt_q % 3 != 0) begin
      valid_o <= 1'b1;
      word_o  <= words[0];
    end else if (!valid_o) begin
      word_o <= ~word_o;
    end
  end
endmodule
